//--- rtl/spi_eeprom_serial_front_end.sv
// How it works
// - instruction byte captured into 8-bit register
// - input bit shifted on each rising clock
// - status write refused while protect pin guards
// - all bytes move most significant bit first
// - first bit on first rise after select
// - paused device ignores all but select
// - resume from the exact paused bit position
// - self-timed write starts at select rise
// - clock may idle low or high
// - 4096 by 8 byte array over link
// - output bit changes after falling clock
// - fixed codes for latch and status commands
// - status byte layout, readable while busy
// - hardware guard needs pin low, enable high
`timescale 1ns/1ns
`default_nettype none
`include "spi_eeprom_consts.svh"

module spi_eeprom_serial_front_end
	import spi_eeprom_pkg::*;
#(
	parameter int WRITE_CYCLES =
		(`WRITE_TIME_MS * `NS_PER_MS) / `CLK_PERIOD_NS
) (
	// clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       rst_n_i,
	// serial link pins
	input  wire logic       cs_n_i,
	input  wire logic       sck_i,
	input  wire logic       si_i,
	input  wire logic       hold_n_i,
	input  wire logic       wp_n_i,
	output var  logic       so_o,
	output var  logic       so_oe_o,
	// device state
	output var  logic [7:0] status_o,
	output var  logic       busy_o
);

	localparam int TW = $clog2(WRITE_CYCLES + 1);
	localparam logic [TW-1:0] LAST_TICK = TW'(WRITE_CYCLES - 1);

	// ==========================================
	// pin synchronisers
	logic [`PIN_COUNT-1:0] pins_s;
	logic cs_n_s;
	logic sck_s;
	logic si_s;
	logic hold_n_s;
	logic wp_n_s;

	pin_sync #(
		.WIDTH     (`PIN_COUNT),
		.RESET_VAL (`PIN_RESET_VAL)
	) u_pin_sync (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.async_i   ({cs_n_i, sck_i, si_i, hold_n_i, wp_n_i}),
		.sync_o    (pins_s)
	);

	assign {cs_n_s, sck_s, si_s, hold_n_s, wp_n_s} = pins_s;

	// ==========================================
	// edge finding on the sampled pins
	logic sck_d_reg;
	logic cs_n_d_reg;
	logic selected;
	logic held;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			sck_d_reg  <= 1'b0;
			cs_n_d_reg <= 1'b1;
		end else begin
			sck_d_reg  <= sck_s;
			cs_n_d_reg <= cs_n_s;
		end
	end

	assign selected = !cs_n_s;
	assign cs_rise  = cs_n_s && !cs_n_d_reg;
	assign held     = selected && !hold_n_s;
	// both idle levels work, only edges matter
	assign sck_rise = sck_s && !sck_d_reg && selected && !held;
	assign sck_fall = !sck_s && sck_d_reg && selected && !held;

	// ==========================================
	// byte assembly
	logic [2:0] bit_cnt_reg;
	logic [6:0] shift_reg;
	byte_t      rx_byte;
	logic       byte_done;
	logic       aligned;

	// msb arrives first, lsb closes the byte
	assign rx_byte   = {shift_reg, si_s};
	assign byte_done = sck_rise && (bit_cnt_reg == 3'h7);
	assign aligned   = (bit_cnt_reg == 3'h0);

	// counting restarts so the first rise is bit 7
	// a pause freezes the count where it stood
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || !selected) begin
			bit_cnt_reg <= 3'h0;
		end else if (sck_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			shift_reg <= 7'h00;
		end else if (sck_rise) begin
			shift_reg <= rx_byte[6:0];
		end
	end

	// ==========================================
	// status bits and write engine state
	logic       ppe_reg;
	logic [1:0] guard_reg;
	logic       wel_reg;
	wr_state_e  wr_state_reg;
	logic       busy;
	logic       hw_protect;
	byte_t      status_now;

	assign busy = (wr_state_reg == WR_RUN);
	// guard only with pin low and enable set
	assign hw_protect = !wp_n_s && ppe_reg;
	assign status_now = {ppe_reg, 3'h0, guard_reg, wel_reg, busy};

	// ==========================================
	// instruction decode
	phase_e phase_reg;
	byte_t  instr_reg;
	addr_t  addr_reg;
	byte_t  status_in_reg;
	logic   data_seen_reg;
	byte_t  mem [0:`MEM_DEPTH-1];

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || !selected) begin
			phase_reg     <= PH_CMD;
			data_seen_reg <= 1'b0;
		end else if (byte_done) begin
			case (phase_reg)
				PH_CMD: begin
					if (busy && rx_byte != `CMD_STATUS_READ) begin
						phase_reg <= PH_IGNORE;
					end else begin
						case (rx_byte)
							`CMD_ARRAY_READ:        phase_reg <= PH_ADDR_HI;
							`CMD_ARRAY_WRITE:       phase_reg <= PH_ADDR_HI;
							`CMD_STATUS_WRITE:      phase_reg <= PH_STATUS_IN;
							`CMD_STATUS_READ:       phase_reg <= PH_STATUS_OUT;
							`CMD_SET_WRITE_LATCH:   phase_reg <= PH_DONE;
							`CMD_CLEAR_WRITE_LATCH: phase_reg <= PH_DONE;
							default:                phase_reg <= PH_IGNORE;
						endcase
					end
				end
				PH_ADDR_HI:   phase_reg <= PH_ADDR_LO;
				PH_ADDR_LO: begin
					if (instr_reg == `CMD_ARRAY_WRITE) begin
						phase_reg <= PH_DATA;
					end else begin
						phase_reg <= PH_READ;
					end
				end
				PH_DATA:      data_seen_reg <= 1'b1;
				PH_STATUS_IN: phase_reg <= PH_DONE;
				PH_DONE:      phase_reg <= PH_IGNORE;
				default:      phase_reg <= phase_reg;
			endcase
		end
	end

	// whole instruction byte held before decoding acts
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			instr_reg     <= 8'h00;
			status_in_reg <= 8'h00;
		end else if (byte_done && phase_reg == PH_CMD) begin
			instr_reg <= rx_byte;
		end else if (byte_done && phase_reg == PH_STATUS_IN) begin
			status_in_reg <= rx_byte;
		end
	end

	// twelve address bits, top nibble of the high byte unused
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			addr_reg <= 12'h000;
		end else if (byte_done) begin
			case (phase_reg)
				PH_ADDR_HI: addr_reg[11:8] <= rx_byte[3:0];
				PH_ADDR_LO: begin
					if (instr_reg == `CMD_ARRAY_WRITE) begin
						addr_reg[7:0] <= rx_byte;
					end else begin
						addr_reg <= {addr_reg[11:8], rx_byte} + 12'h001;
					end
				end
				PH_READ: addr_reg <= addr_reg + 12'h001;
				default: addr_reg <= addr_reg;
			endcase
		end
	end

	// ==========================================
	// end of selection: commit commands
	logic start_status;
	logic start_data;
	logic frame_ok;

	assign frame_ok = cs_rise && aligned && !busy;
	// status write needs the latch and no hardware guard
	assign start_status = frame_ok && phase_reg == PH_DONE &&
	                      instr_reg == `CMD_STATUS_WRITE &&
	                      wel_reg && !hw_protect;
	assign start_data = frame_ok && phase_reg == PH_DATA &&
	                    data_seen_reg && wel_reg;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			wel_reg <= 1'b0;
		end else if (start_status || start_data) begin
			wel_reg <= 1'b0;
		end else if (frame_ok && phase_reg == PH_DONE) begin
			if (instr_reg == `CMD_SET_WRITE_LATCH) begin
				wel_reg <= 1'b1;
			end else if (instr_reg == `CMD_CLEAR_WRITE_LATCH) begin
				wel_reg <= 1'b0;
			end
		end
	end

	// ==========================================
	// write data buffer
	stream_if #(.WIDTH(`DATA_W)) fill_s ();
	stream_if #(.WIDTH(`DATA_W)) drain_s ();
	logic flush;

	// a write that is not committed leaves nothing behind;
	// a status read during a write must not empty the buffer
	assign flush = cs_rise && !start_data && !busy;
	// bytes beyond the buffer depth are dropped while full
	assign fill_s.valid  = byte_done && phase_reg == PH_DATA;
	assign fill_s.data   = rx_byte;
	assign drain_s.ready = busy;

	byte_fifo #(
		.WIDTH (`DATA_W),
		.DEPTH (`FIFO_DEPTH)
	) u_byte_fifo (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.flush_i   (flush),
		.fill_s    (fill_s),
		.drain_s   (drain_s)
	);

	// ==========================================
	// self-timed write
	function automatic logic guarded(input addr_t a, input logic [1:0] g);
		case (g)
			2'h0:    guarded = 1'b0;
			2'h1:    guarded = (a >= `GUARD_QUARTER_LO);
			2'h2:    guarded = (a >= `GUARD_HALF_LO);
			default: guarded = 1'b1;
		endcase
	endfunction : guarded

	logic [TW-1:0] timer_reg;
	logic          wr_status_reg;
	addr_t         wr_ptr_reg;
	logic          drain_go;

	assign drain_go = drain_s.valid && busy;

	// begins at select rise, ends inside the write time
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			wr_state_reg  <= WR_IDLE;
			timer_reg     <= '0;
			wr_status_reg <= 1'b0;
		end else begin
			case (wr_state_reg)
				WR_IDLE: begin
					if (start_status || start_data) begin
						wr_state_reg  <= WR_RUN;
						timer_reg     <= '0;
						wr_status_reg <= start_status;
					end
				end
				WR_RUN: begin
					timer_reg <= timer_reg + 1'b1;
					if (timer_reg == LAST_TICK) begin
						wr_state_reg <= WR_IDLE;
					end
				end
				default: wr_state_reg <= WR_IDLE;
			endcase
		end
	end

	// nonvolatile status bits settle when the cycle ends
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ppe_reg   <= `STAT_PROTECT_PIN_EN_RST;
			guard_reg <= `STAT_GUARD_RST;
		end else if (busy && timer_reg == LAST_TICK && wr_status_reg) begin
			ppe_reg   <= status_in_reg[`STAT_PROTECT_PIN_EN_BIT];
			guard_reg <= {status_in_reg[`STAT_GUARD_HIGH_BIT],
			              status_in_reg[`STAT_GUARD_LOW_BIT]};
		end
	end

	// page wrap keeps the upper address bits fixed
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			wr_ptr_reg <= 12'h000;
		end else if (start_data) begin
			wr_ptr_reg <= addr_reg;
		end else if (drain_go) begin
			wr_ptr_reg[`PAGE_W-1:0] <= wr_ptr_reg[`PAGE_W-1:0] + 5'h01;
		end
	end

	// byte array, guarded blocks skip the store
	always_ff @(posedge ref_clk_i) begin
		if (drain_go && !guarded(wr_ptr_reg, guard_reg)) begin
			mem[wr_ptr_reg] <= drain_s.data;
		end
	end

	// ==========================================
	// output shifter
	byte_t tx_reg;
	logic  tx_on_reg;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || !selected) begin
			tx_reg    <= 8'h00;
			tx_on_reg <= 1'b0;
		end else if (byte_done && phase_reg == PH_CMD &&
		             rx_byte == `CMD_STATUS_READ) begin
			tx_reg    <= status_now;
			tx_on_reg <= 1'b1;
		end else if (byte_done && phase_reg == PH_STATUS_OUT) begin
			tx_reg <= status_now;
		end else if (byte_done && phase_reg == PH_ADDR_LO &&
		             instr_reg == `CMD_ARRAY_READ) begin
			tx_reg    <= mem[{addr_reg[11:8], rx_byte}];
			tx_on_reg <= 1'b1;
		end else if (byte_done && phase_reg == PH_READ) begin
			tx_reg <= mem[addr_reg];
		end else if (sck_fall && tx_on_reg) begin
			tx_reg <= {tx_reg[6:0], 1'b0};
		end
	end

	// new bit presented after each falling edge
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			so_o <= 1'b0;
		end else if (sck_fall && tx_on_reg) begin
			so_o <= tx_reg[7];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			so_oe_o <= 1'b0;
		end else begin
			so_oe_o <= tx_on_reg && selected && !held;
		end
	end

	// ==========================================
	// state outputs
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			status_o <= 8'h00;
			busy_o   <= 1'b0;
		end else begin
			status_o <= status_now;
			busy_o   <= busy;
		end
	end

endmodule : spi_eeprom_serial_front_end

`default_nettype wire

//--- rtl/spi_eeprom_consts.svh
`ifndef SPI_EEPROM_CONSTS_SVH
`define SPI_EEPROM_CONSTS_SVH

// ==========================================
// instruction codes
`define CMD_SET_WRITE_LATCH   8'h06
`define CMD_CLEAR_WRITE_LATCH 8'h04
`define CMD_STATUS_READ       8'h05
`define CMD_STATUS_WRITE      8'h01
`define CMD_ARRAY_READ        8'h03
`define CMD_ARRAY_WRITE       8'h02

// ==========================================
// status byte layout
`define STAT_PROTECT_PIN_EN_BIT 7
`define STAT_GUARD_HIGH_BIT     3
`define STAT_GUARD_LOW_BIT      2
`define STAT_WRITE_LATCH_BIT    1
`define STAT_WRITE_BUSY_BIT     0
`define STAT_PROTECT_PIN_EN_RST 1'b0
`define STAT_GUARD_RST          2'h0

// ==========================================
// array geometry and guarded regions
`define MEM_DEPTH        4096
`define ADDR_W           12
`define ADDR_HI_W        4
`define PAGE_W           5
`define GUARD_QUARTER_LO 12'h0C00
`define GUARD_HALF_LO    12'h0800

// ==========================================
// buffering
`define DATA_W     8
`define FIFO_DEPTH 16

// ==========================================
// pins in order {cs_n, sck, si, hold_n, wp_n}
`define PIN_COUNT     5
`define PIN_RESET_VAL 5'h13

// ==========================================
// timing
`define CLK_PERIOD_NS 50
`define NS_PER_MS     1000000
`define WRITE_TIME_MS 5

`endif

//--- rtl/spi_eeprom_pkg.sv
`default_nettype none
package spi_eeprom_pkg;

	typedef logic [7:0]  byte_t;
	typedef logic [11:0] addr_t;

	typedef enum logic [3:0] {
		PH_CMD,
		PH_ADDR_HI,
		PH_ADDR_LO,
		PH_DATA,
		PH_STATUS_IN,
		PH_DONE,
		PH_READ,
		PH_STATUS_OUT,
		PH_IGNORE
	} phase_e;

	typedef enum logic {
		WR_IDLE,
		WR_RUN
	} wr_state_e;

endpackage : spi_eeprom_pkg

`default_nettype wire

//--- rtl/stream_if.sv
`timescale 1ns/1ns
`default_nettype none

interface stream_if #(
	parameter int WIDTH = 8
);
	logic [WIDTH-1:0] data;
	logic             valid;
	logic             ready;

	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : stream_if

`default_nettype wire

//--- rtl/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
	parameter int              WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// clock and reset
	input  wire logic             ref_clk_i,
	input  wire logic             rst_n_i,
	// pins
	input  wire logic [WIDTH-1:0] async_i,
	output var  logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_reg;

	// ==========================================
	// two flops per pin; only the second reads the first
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge ref_clk_i) begin
				if (!rst_n_i) begin
					meta_reg[g] <= RESET_VAL[g];
					sync_o[g]   <= RESET_VAL[g];
				end else begin
					meta_reg[g] <= async_i[g];
					sync_o[g]   <= meta_reg[g];
				end
			end
		end
	endgenerate

endmodule : pin_sync

`default_nettype wire

//--- rtl/byte_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rst_n_i,
	// discard everything held
	input  wire logic flush_i,
	// streams
	stream_if.snk     fill_s,
	stream_if.src     drain_s
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic [PW:0]      wr_ptr_reg;
	logic [PW:0]      rd_ptr_reg;
	logic             full;
	logic             empty;
	logic             push;
	logic             pop;

	// ==========================================
	// flags from pointers carrying a wrap bit
	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign full  = (wr_ptr_reg[PW] != rd_ptr_reg[PW]) &&
	               (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]);
	assign fill_s.ready  = !full;
	assign drain_s.valid = !empty;
	assign drain_s.data  = store[rd_ptr_reg[PW-1:0]];
	assign push = fill_s.valid && !full && !flush_i;
	assign pop  = drain_s.ready && !empty && !flush_i;

	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			store[wr_ptr_reg[PW-1:0]] <= fill_s.data;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || flush_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end

endmodule : byte_fifo

`default_nettype wire

//--- tb/fe_checker.sv
`timescale 1ns/1ns
`default_nettype none
module fe_checker #(
	parameter int WRITE_CYCLES = 100000
) (
	// clock and reset
	input wire logic       ref_clk_i,
	input wire logic       rst_n_i,
	// pins
	input wire logic       cs_n_i,
	input wire logic       sck_i,
	input wire logic       hold_n_i,
	input wire logic       so_o,
	input wire logic       so_oe_o,
	// state
	input wire logic [7:0] status_o,
	input wire logic       busy_o
);
	default clocking dc @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// ==========================================
	// busy length, too long to unroll
	int len_reg;
	always_ff @(posedge ref_clk_i) begin
		if (!busy_o) begin
			len_reg <= 0;
		end else begin
			len_reg <= len_reg + 1;
		end
	end
	// ==========================================
	// properties
	AST_OE_DESEL: assert property (cs_n_i [*4] |-> !so_oe_o)
		else $error("so driven while deselected");
	AST_OE_PAUSE: assert property (!hold_n_i [*4] |-> !so_oe_o)
		else $error("so driven while paused");
	AST_WR_LEN: assert property ($fell(busy_o) |-> len_reg == WRITE_CYCLES)
		else $error("write cycle length wrong");
	AST_WR_START: assert property ($rose(busy_o) |->
		$past(cs_n_i) && $past(cs_n_i, 2) && $past(cs_n_i, 3))
		else $error("write began while selected");
	AST_LATCH_WR: assert property (busy_o && $past(busy_o) |-> !status_o[1])
		else $error("latch set during write");
	AST_NV_END: assert property ($changed({status_o[7], status_o[3:2]}) |->
		$past(busy_o) || $past(busy_o, 2))
		else $error("status changed outside write end");
	AST_SO_FALL: assert property (so_oe_o && $past(so_oe_o) && hold_n_i
		&& !cs_n_i && $changed(so_o) |-> !sck_i && !$past(sck_i, 2))
		else $error("so changed off falling clock");
	AST_RST: assert property ($rose(rst_n_i) |->
		status_o == 8'h00 && !so_oe_o && !busy_o)
		else $error("outputs not clear after reset");
endmodule : fe_checker

bind spi_eeprom_serial_front_end fe_checker #(
	.WRITE_CYCLES(WRITE_CYCLES)
) chk_u (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
	.sck_i(sck_i), .hold_n_i(hold_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
	.status_o(status_o), .busy_o(busy_o)
);
`default_nettype wire

//--- tb/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model (
	// clock
	input  wire logic       ref_clk_i,
	// link pins
	output var  logic       cs_n_o,
	output var  logic       sck_o,
	output var  logic       si_o,
	output var  logic       hold_n_o,
	output var  logic       wp_n_o,
	input  wire logic       so_i,
	input  wire logic       so_oe_i,
	// received bytes
	output var  logic [7:0] rx_byte_o,
	output var  logic       rx_valid_o
);
	// idle link levels before the first frame
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b0;
		hold_n_o = 1'b1;
		wp_n_o = 1'b1;
		rx_byte_o = 8'h00;
		rx_valid_o = 1'b0;
	end
	logic       idle_reg = 1'b0;
	logic       last_reg = 1'b0;
	logic [7:0] sh_reg = 8'h00;
	logic       so_line;
	assign so_line = so_oe_i ? so_i : ~last_reg;
	always @(posedge ref_clk_i) if (so_oe_i) last_reg <= so_i;
	task automatic wait_clk(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask : wait_clk
	task automatic begin_f(input logic cpol);
		@(posedge ref_clk_i);
		idle_reg = cpol;
		sck_o <= cpol;
		wait_clk(4);
		cs_n_o <= 1'b0;
		wait_clk(4);
	endtask : begin_f
	task automatic end_f();
		sck_o <= idle_reg;
		wait_clk(4);
		cs_n_o <= 1'b1;
		wait_clk(6);
	endtask : end_f
	task automatic xfer(input logic [7:0] v, input int n, input logic cap);
		for (int i = n - 1; i >= 0; i--) begin
			sck_o <= 1'b0;
			si_o <= v[i];
			wait_clk(4);
			sck_o <= 1'b1;
			sh_reg = {sh_reg[6:0], so_line};
			wait_clk(4);
		end
		if (cap) begin
			rx_byte_o <= sh_reg;
			rx_valid_o <= 1'b1;
			wait_clk(1);
			rx_valid_o <= 1'b0;
		end
	endtask : xfer
	task automatic pause(input int n);
		sck_o <= 1'b0;
		wait_clk(4);
		hold_n_o <= 1'b0;
		wait_clk(4);
		repeat (n) begin
			sck_o <= 1'b1;
			si_o <= 1'($urandom);
			wait_clk(4);
			sck_o <= 1'b0;
			wait_clk(4);
		end
		hold_n_o <= 1'b1;
		wait_clk(4);
	endtask : pause
	task automatic set_wp(input logic v);
		@(posedge ref_clk_i);
		wp_n_o <= v;
	endtask : set_wp
endmodule : host_model
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "spi_eeprom_consts.svh"
module testbench
	import spi_eeprom_pkg::*;
;
	localparam int WR_CYC = 400;
	logic       ref_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       cs_n, sck, si, hold_n, wp_n, so, so_oe, busy, rx_valid;
	logic [7:0] status, rx_byte;
	byte_t      exp_q[$];
	byte_t      d[3];
	addr_t      a;
	int         num_errors = 0;
	int         total_checks = 0;
	always #25 ref_clk = ~ref_clk;
	spi_eeprom_serial_front_end #(.WRITE_CYCLES(WR_CYC)) dut_u (
		.ref_clk_i(ref_clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sck_i(sck),
		.si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so),
		.so_oe_o(so_oe), .status_o(status), .busy_o(busy));
	host_model host_u (
		.ref_clk_i(ref_clk), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
		.hold_n_o(hold_n), .wp_n_o(wp_n), .so_i(so), .so_oe_i(so_oe),
		.rx_byte_o(rx_byte), .rx_valid_o(rx_valid));
	task automatic check_byte(input string w, input byte_t e, input byte_t g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s exp %h got %h", w, e, g);
		end
	endtask : check_byte
	task automatic check_bit(input string w, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s exp %b got %b", w, e, g);
		end
	endtask : check_bit
	task automatic frame(input byte_t b[$], input logic cpol, input int rd);
		host_u.begin_f(cpol);
		foreach (b[i]) host_u.xfer(b[i], 8, 1'b0);
		repeat (rd) host_u.xfer(8'h00, 8, 1'b1);
		host_u.end_f();
	endtask : frame
	task automatic rd_status(input byte_t e, input logic cpol);
		exp_q.push_back(e);
		frame('{`CMD_STATUS_READ}, cpol, 1);
		check_bit("so_oe_o", 1'b0, so_oe);
	endtask : rd_status
	task automatic wait_idle();
		repeat (WR_CYC + 20) begin
			if (busy === 1'b0) break;
			@(posedge ref_clk);
		end
		check_bit("busy_o", 1'b0, busy);
	endtask : wait_idle
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test
	// ==========================================
	// oldest note against each received byte
	always @(posedge ref_clk) begin
		if (rx_valid === 1'b1) begin
			check_byte("rx_byte", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rx_byte);
		end
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		$display("mismatch watchdog exp done got hang");
		stop_test();
	end
	// ==========================================
	// scenarios
	initial begin
		void'($urandom(32'h9e77_224e));
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd_status(8'h00, 1'b0);
		frame('{`CMD_SET_WRITE_LATCH}, 1'b1, 0);
		rd_status(8'h02, 1'b1);
		frame('{`CMD_CLEAR_WRITE_LATCH}, 1'b0, 0);
		rd_status(8'h00, 1'b0);
		// a cut-short byte must leave nothing behind
		host_u.begin_f(1'b0);
		host_u.xfer(8'h06, 5, 1'b0);
		host_u.end_f();
		rd_status(8'h00, 1'b1);
		frame('{`CMD_SET_WRITE_LATCH}, 1'b0, 0);
		exp_q.push_back(8'h02);
		host_u.begin_f(1'b0);
		host_u.xfer(8'h00, 3, 1'b0);
		host_u.pause(3);
		host_u.xfer(`CMD_STATUS_READ, 5, 1'b0);
		host_u.xfer(8'h00, 4, 1'b0);
		host_u.pause(2);
		host_u.xfer(8'h00, 4, 1'b1);
		host_u.end_f();
		frame('{`CMD_STATUS_WRITE, 8'h8c}, 1'b0, 0);
		check_bit("busy_o", 1'b1, busy);
		rd_status(8'h01, 1'b1);
		wait_idle();
		rd_status(8'h8c, 1'b0);
		frame('{`CMD_SET_WRITE_LATCH}, 1'b0, 0);
		host_u.set_wp(1'b0);
		frame('{`CMD_STATUS_WRITE, 8'h00}, 1'b1, 0);
		check_bit("busy_o", 1'b0, busy);
		rd_status(8'h8e, 1'b0);
		host_u.set_wp(1'b1);
		frame('{`CMD_STATUS_WRITE, 8'h00}, 1'b0, 0);
		wait_idle();
		rd_status(8'h00, 1'b0);
		// third byte wraps to the page start
		frame('{`CMD_SET_WRITE_LATCH}, 1'b0, 0);
		a = {7'($urandom), 5'h1e};
		foreach (d[i]) d[i] = 8'($urandom);
		frame('{`CMD_ARRAY_WRITE, {4'($urandom), a[11:8]}, a[7:0],
			d[0], d[1], d[2]}, 1'b1, 0);
		wait_idle();
		exp_q.push_back(d[0]);
		exp_q.push_back(d[1]);
		frame('{`CMD_ARRAY_READ, {4'h0, a[11:8]}, a[7:0]}, 1'b1, 2);
		exp_q.push_back(d[2]);
		frame('{`CMD_ARRAY_READ, {4'h0, a[11:8]}, {a[7:5], 5'h00}}, 1'b0, 1);
		// guarded block keeps old data; latch set refused while busy
		frame('{`CMD_SET_WRITE_LATCH}, 1'b0, 0);
		frame('{`CMD_STATUS_WRITE, 8'h0c}, 1'b1, 0);
		wait_idle();
		frame('{`CMD_SET_WRITE_LATCH}, 1'b0, 0);
		frame('{`CMD_ARRAY_WRITE, {4'h0, a[11:8]}, a[7:0], ~d[0]}, 1'b0, 0);
		check_bit("busy_o", 1'b1, busy);
		frame('{`CMD_SET_WRITE_LATCH}, 1'b1, 0);
		rd_status(8'h0d, 1'b0);
		wait_idle();
		check_byte("status_o", 8'h0c, status);
		rd_status(8'h0c, 1'b1);
		exp_q.push_back(d[0]);
		frame('{`CMD_ARRAY_READ, {4'h0, a[11:8]}, a[7:0]}, 1'b0, 1);
		repeat (10) @(posedge ref_clk);
		check_bit("queue_empty", 1'b1, exp_q.size() == 0);
		stop_test();
	end
endmodule : testbench
`default_nettype wire
